// >>> rtl/asp_cfg.svh
/*
 * constants for the scan-mode and power control block: word layout,
 * scan codes, power field codes, sequence depth and warm-up count.
 * assumes 16-bit frames shifted msb first on the serial port.
 */
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
`define ASP_WORD_BITS      16
`define ASP_CNT_W          5
`define ASP_SEL_BIT        15
`define ASP_SCAN_HI        14
`define ASP_SCAN_LO        11
`define ASP_CHSEL_HI       10
`define ASP_CHSEL_LO       7
`define ASP_PM_HI          5
`define ASP_PM_LO          4
`define ASP_SOFTWARE_CONVERT_TRIGGER_BIT      1
`define ASP_SPM_HI         3
`define ASP_SPM_LO         2
`define ASP_SEQ_DEPTH      256
`define ASP_SCAN_SEQ       4'h9
`define ASP_SCAN_RSV_MIN   4'ha
`define ASP_SCAN_STD_INT   4'h3
`define ASP_SCAN_UPR_INT   4'h5
`define ASP_SCAN_CUS_INT   4'h7
`define ASP_PM_NORMAL      2'h0
`define ASP_PM_FULL_OFF    2'h1
`define ASP_PM_BIAS_KEEP   2'h2
`define ASP_SPM_NONE       2'h0
`define ASP_SPM_FULL       2'h1
`define ASP_SPM_PARTIAL    2'h2
`define ASP_WARM_CONVS     2'h2
`define ASP_SCAN_RESET     4'h0
`endif

// >>> rtl/asp_pkg.sv
/*
 * types shared by the scan-mode and power control block.
 * assumes asp_cfg.svh for the numeric constants.
 */
package asp_pkg;
   typedef enum logic [1:0] {
      ASP_PWR_ON,
      ASP_PWR_FULL_OFF,
      ASP_PWR_BIAS_ONLY
   } asp_pwr_type;
endpackage

// >>> rtl/asp_pin_sync.sv
/*
 * three-stage pin synchroniser with agreement filter and edge pulses.
 * assumes an asynchronous pin and one synchronous active-high reset.
 */
module asp_pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input  wire logic clk_in,    // block clock
   input  wire logic srst_in,   // sync reset
   input  wire logic pin_in,    // raw pin
   output logic      level_out, // filtered level
   output logic      rise_out,  // rising edge pulse
   output logic      fall_out   // falling edge pulse
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s1_reg <= RESET_LEVEL;
         s2_reg <= RESET_LEVEL;
         s3_reg <= RESET_LEVEL;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // level moves only when stages two and three agree
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         level_out <= RESET_LEVEL;
         rise_out  <= 1'b0;
         fall_out  <= 1'b0;
      end else begin
         rise_out <= (s2_reg == s3_reg) && s3_reg && !level_out;
         fall_out <= (s2_reg == s3_reg) && !s3_reg && level_out;
         if (s2_reg == s3_reg) begin
            level_out <= s3_reg;
         end
      end
   end
endmodule

// >>> rtl/asp_scan_power.sv
/*
 * scan-mode decode, channel selection, programmable sequence and
 * power-down sequencing behind a 3-wire serial port.
 * assumes pins are asynchronous to clk_in; the serial clock idles
 * low and data is taken on its rising edge; the converter core
 * reports end of an internal-clock conversion set on conv_done_in.
 */
`include "asp_cfg.svh"

module asp_scan_power (
   input  wire logic       clk_in,                // 250 MHz block clock
   input  wire logic       srst_in,               // sync reset, high
   input  wire logic       cs_n_pin_in,           // chip select, low active
   input  wire logic       sclk_pin_in,           // serial clock pin
   input  wire logic       sdi_pin_in,            // serial data in pin
   input  wire logic       convert_start_pin_n_in,// start pin, low active
   input  wire logic       conv_done_in,          // internal set finished
   input  wire logic       avg_req_in,            // averaging wanted
   input  wire logic       seq_wr_in,             // sequence entry write
   input  wire logic [7:0] seq_wr_addr_in,        // entry index
   input  wire logic [3:0] seq_wr_chan_in,        // entry channel
   input  wire logic [7:0] seq_last_in,           // index of last entry
   output logic [3:0]      scan_mode_out,         // active scan code
   output logic [3:0]      channel_selector_out,  // stored selector
   output logic [3:0]      active_channel_out,    // channel to convert
   output logic [1:0]      auto_power_mode_out,   // stored auto field
   output logic [1:0]      static_power_field_out,// stored static field
   output logic            ext_clock_mode_out,    // external clock mode
   output logic            avg_en_out,            // averaging enable
   output logic            core_power_out,        // core powered
   output logic            bias_power_out,        // bias powered
   output logic            convert_req_out,       // internal start pulse
   output logic            result_valid_out       // conversion usable
);
   logic        cs_lvl;
   logic        cs_rise;
   logic        cs_fall;
   logic        sclk_rise;
   logic        sdi_lvl;
   logic        cnv_fall;
   logic [`ASP_WORD_BITS-1:0] shift_reg;
   logic [`ASP_CNT_W-1:0]     bit_cnt_reg;
   logic        word_ok;
   logic        is_mode_word;
   logic        is_cfg_word;
   logic [3:0]  word_scan;
   logic        scan_ok;
   logic        software_convert_trigger_req;
   logic [3:0]  seq_mem [`ASP_SEQ_DEPTH];
   logic [7:0]  seq_ptr_reg;
   logic        seq_mode;
   logic        int_mode;
   logic        conv_evt;
   logic        auto_on;
   logic        wake_evt;
   logic        sleep_evt;
   logic [1:0]  warm_reg;
   asp_pkg::asp_pwr_type pwr_reg;
   asp_pkg::asp_pwr_type pwr_next;
   asp_pkg::asp_pwr_type auto_target;

   asp_pin_sync #(.RESET_LEVEL(1'b1)) u_cs (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .pin_in    (cs_n_pin_in),
      .level_out (cs_lvl),
      .rise_out  (cs_rise),
      .fall_out  (cs_fall)
   );

   asp_pin_sync #(.RESET_LEVEL(1'b0)) u_sclk (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .pin_in    (sclk_pin_in),
      .level_out (),
      .rise_out  (sclk_rise),
      .fall_out  ()
   );

   asp_pin_sync #(.RESET_LEVEL(1'b0)) u_sdi (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .pin_in    (sdi_pin_in),
      .level_out (sdi_lvl),
      .rise_out  (),
      .fall_out  ()
   );

   asp_pin_sync #(.RESET_LEVEL(1'b1)) u_cnv (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .pin_in    (convert_start_pin_n_in),
      .level_out (),
      .rise_out  (),
      .fall_out  (cnv_fall)
   );

   // serial shifter, msb first, one word per frame
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         shift_reg   <= '0;
         bit_cnt_reg <= '0;
      end else if (cs_fall) begin
         bit_cnt_reg <= '0;
      end else if (!cs_lvl && sclk_rise) begin
         shift_reg <= {shift_reg[`ASP_WORD_BITS-2:0], sdi_lvl};
         if (bit_cnt_reg != `ASP_CNT_W'(`ASP_WORD_BITS)) begin
            bit_cnt_reg <= bit_cnt_reg + `ASP_CNT_W'(1);
         end
      end
   end

   assign word_ok      = cs_rise && (bit_cnt_reg == `ASP_CNT_W'(`ASP_WORD_BITS));
   assign is_mode_word = word_ok && !shift_reg[`ASP_SEL_BIT];
   assign is_cfg_word  = word_ok && shift_reg[`ASP_SEL_BIT];
   assign word_scan    = shift_reg[`ASP_SCAN_HI:`ASP_SCAN_LO];
   assign scan_ok      = word_scan < `ASP_SCAN_RSV_MIN;
   assign software_convert_trigger_req    = is_mode_word && scan_ok && shift_reg[`ASP_SOFTWARE_CONVERT_TRIGGER_BIT];

   // mode word: reserved codes leave mode and low fields untouched
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         scan_mode_out        <= `ASP_SCAN_RESET;
         channel_selector_out <= 4'h0;
         auto_power_mode_out  <= `ASP_PM_NORMAL;
      end else if (is_mode_word && scan_ok) begin
         scan_mode_out        <= word_scan;
         channel_selector_out <= shift_reg[`ASP_CHSEL_HI:`ASP_CHSEL_LO];
         auto_power_mode_out  <= shift_reg[`ASP_PM_HI:`ASP_PM_LO];
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         static_power_field_out <= `ASP_SPM_NONE;
      end else if (is_cfg_word) begin
         static_power_field_out <= shift_reg[`ASP_SPM_HI:`ASP_SPM_LO];
      end
   end

   // clock mode follows the scan code; sequence mode is external only
   assign seq_mode = scan_mode_out == `ASP_SCAN_SEQ;
   assign int_mode = (scan_mode_out == `ASP_SCAN_STD_INT) ||
                     (scan_mode_out == `ASP_SCAN_UPR_INT) ||
                     (scan_mode_out == `ASP_SCAN_CUS_INT);

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ext_clock_mode_out <= 1'b1;
         avg_en_out         <= 1'b0;
      end else begin
         ext_clock_mode_out <= !int_mode;
         avg_en_out         <= int_mode && !seq_mode && avg_req_in;
      end
   end

   // sequence list: any channel at any index, no ordering imposed
   always_ff @(posedge clk_in) begin
      if (seq_wr_in) begin
         seq_mem[seq_wr_addr_in] <= seq_wr_chan_in;
      end
   end

   // one conversion per frame in external mode
   assign conv_evt = int_mode ? conv_done_in : cs_rise;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         seq_ptr_reg <= 8'h00;
      end else if (!seq_mode) begin
         seq_ptr_reg <= 8'h00;
      end else if (conv_evt && pwr_reg == asp_pkg::ASP_PWR_ON) begin
         if (seq_ptr_reg >= seq_last_in) begin
            seq_ptr_reg <= 8'h00;
         end else begin
            seq_ptr_reg <= seq_ptr_reg + 8'h01;
         end
      end
   end

   // selector value is the input number as is
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         active_channel_out <= 4'h0;
      end else if (seq_mode) begin
         active_channel_out <= seq_mem[seq_ptr_reg];
      end else begin
         active_channel_out <= channel_selector_out;
      end
   end

   // power sequencing
   assign auto_on = (auto_power_mode_out == `ASP_PM_FULL_OFF) ||
                    (auto_power_mode_out == `ASP_PM_BIAS_KEEP);
   assign auto_target = (auto_power_mode_out == `ASP_PM_BIAS_KEEP) ?
                        asp_pkg::ASP_PWR_BIAS_ONLY :
                        asp_pkg::ASP_PWR_FULL_OFF;
   assign sleep_evt = auto_on && (int_mode ? conv_done_in
                                           : cs_rise);
   assign wake_evt  = int_mode ? (cnv_fall || software_convert_trigger_req)
                               : cs_fall;

   always_comb begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         asp_pkg::ASP_PWR_ON: begin
            if (sleep_evt) begin
               pwr_next = auto_target;
            end
         end
         asp_pkg::ASP_PWR_FULL_OFF,
         asp_pkg::ASP_PWR_BIAS_ONLY: begin
            if (!auto_on || wake_evt) begin
               pwr_next = asp_pkg::ASP_PWR_ON;
            end
         end
         default: begin
            pwr_next = asp_pkg::ASP_PWR_ON;
         end
      endcase
   end

   // settings registers have no reset or clear path from these states
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pwr_reg <= asp_pkg::ASP_PWR_ON;
      end else begin
         pwr_reg <= pwr_next;
      end
   end

   // static full and partial codes override the automatic state
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         core_power_out <= 1'b1;
         bias_power_out <= 1'b1;
      end else if (static_power_field_out == `ASP_SPM_FULL) begin
         core_power_out <= 1'b0;
         bias_power_out <= 1'b0;
      end else if (static_power_field_out == `ASP_SPM_PARTIAL) begin
         core_power_out <= 1'b0;
         bias_power_out <= 1'b1;
      end else begin
         core_power_out <= pwr_next == asp_pkg::ASP_PWR_ON;
         bias_power_out <= pwr_next != asp_pkg::ASP_PWR_FULL_OFF;
      end
   end

   // start pulse for internal-clock conversions on wake
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         convert_req_out <= 1'b0;
      end else begin
         convert_req_out <= int_mode && wake_evt &&
                            (pwr_reg != asp_pkg::ASP_PWR_ON);
      end
   end

   // warm-up: first conversions after a wake are flagged invalid
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         warm_reg <= 2'h0;
      end else if (pwr_reg != asp_pkg::ASP_PWR_ON &&
                   pwr_next == asp_pkg::ASP_PWR_ON) begin
         warm_reg <= `ASP_WARM_CONVS;
      end else if (conv_evt && warm_reg != 2'h0) begin
         warm_reg <= warm_reg - 2'h1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         result_valid_out <= 1'b0;
      end else begin
         result_valid_out <= conv_evt && core_power_out &&
                             (warm_reg == 2'h0);
      end
   end

   a_rsv_keeps_mode: assert property (@(posedge clk_in) disable iff (srst_in)
      (is_mode_word && !scan_ok) |=> $stable(scan_mode_out) &&
      $stable(channel_selector_out) && $stable(auto_power_mode_out))
      else $error("reserved scan code changed stored settings");

   a_seq_no_avg: assert property (@(posedge clk_in) disable iff (srst_in)
      seq_mode |=> !avg_en_out && ext_clock_mode_out)
      else $error("sequence mode with averaging or internal clock");

   a_chan_direct: assert property (@(posedge clk_in) disable iff (srst_in)
      !seq_mode |=> active_channel_out == $past(channel_selector_out))
      else $error("selected channel differs from selector");

   a_seq_wrap: assert property (@(posedge clk_in) disable iff (srst_in)
      (seq_mode && conv_evt && pwr_reg == asp_pkg::ASP_PWR_ON &&
       seq_ptr_reg >= seq_last_in) |=> seq_ptr_reg == 8'h00)
      else $error("sequence pointer did not wrap");

   a_ext_sleep: assert property (@(posedge clk_in) disable iff (srst_in)
      (!int_mode && auto_on && cs_rise && pwr_reg == asp_pkg::ASP_PWR_ON &&
       static_power_field_out == `ASP_SPM_NONE) |=> !core_power_out)
      else $error("no shutdown at frame end");

   a_ext_wake: assert property (@(posedge clk_in) disable iff (srst_in)
      (!int_mode && cs_fall && pwr_reg != asp_pkg::ASP_PWR_ON)
      |=> pwr_reg == asp_pkg::ASP_PWR_ON)
      else $error("no wake at chip select fall");

   a_int_sleep: assert property (@(posedge clk_in) disable iff (srst_in)
      (int_mode && auto_on && conv_done_in && pwr_reg == asp_pkg::ASP_PWR_ON)
      |=> pwr_reg == auto_target)
      else $error("no shutdown after internal conversions");

   a_normal_on: assert property (@(posedge clk_in) disable iff (srst_in)
      (auto_power_mode_out == `ASP_PM_NORMAL &&
       static_power_field_out == `ASP_SPM_NONE) [*2] |-> core_power_out)
      else $error("powered down in normal mode");

   a_standby_bias: assert property (@(posedge clk_in) disable iff (srst_in)
      (pwr_reg == asp_pkg::ASP_PWR_BIAS_ONLY &&
       static_power_field_out == `ASP_SPM_NONE) |=> bias_power_out)
      else $error("bias lost in standby");

   a_static_full: assert property (@(posedge clk_in) disable iff (srst_in)
      (static_power_field_out == `ASP_SPM_FULL) |=>
      !core_power_out && !bias_power_out)
      else $error("static full shutdown left power on");

   a_warm_invalid: assert property (@(posedge clk_in) disable iff (srst_in)
      (pwr_reg != asp_pkg::ASP_PWR_ON && pwr_next == asp_pkg::ASP_PWR_ON)
      |=> warm_reg == `ASP_WARM_CONVS)
      else $error("warm-up count not loaded on wake");

   a_warm_block: assert property (@(posedge clk_in) disable iff (srst_in)
      (conv_evt && warm_reg != 2'h0) |=> !result_valid_out)
      else $error("result marked valid during warm-up");

   a_sleep_keeps: assert property (@(posedge clk_in) disable iff (srst_in)
      (pwr_reg != pwr_next && !word_ok) |=> $stable(scan_mode_out) &&
      $stable(static_power_field_out))
      else $error("power change altered settings");
endmodule

// >>> verification/asp_host_model.sv
/*
 * host side of the 3-wire serial port and the convert start pin.
 * assumes the block clock as time base; pins change on its falling edge.
 */
module asp_host_model (
   input  wire logic clk_in,      // block clock
   output logic      cs_n_out,    // chip select, low active
   output logic      sclk_out,    // serial clock, still between frames
   output logic      sdi_out,     // serial data, msb first
   output logic      start_n_out  // convert start pin, low active
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 20; // 80 ns half period of the link clock

   initial begin
      cs_n_out    = 1'b1;
      sclk_out    = 1'b0;
      sdi_out     = 1'b0;
      start_n_out = 1'b1;
   end

   task automatic send_word(input logic [15:0] w);
      logic [15:0] v;
      v = w;
      if (!v[15] && v[5:4] == 2'h3) v[5:4] = 2'h0;
      @(negedge clk_in);
      cs_n_out = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi_out = v[i];
         repeat (HALF) @(negedge clk_in);
         sclk_out = 1'b1;
         repeat (HALF) @(negedge clk_in);
         sclk_out = 1'b0;
      end
      repeat (HALF) @(negedge clk_in);
      cs_n_out = 1'b1;
      sdi_out  = ~sdi_out; // released line shows no stale bit
      repeat (HALF) @(negedge clk_in);
   endtask

   task automatic pulse_start();
      @(negedge clk_in);
      start_n_out = 1'b0;
      repeat (HALF) @(negedge clk_in);
      start_n_out = 1'b1;
   endtask
endmodule

// >>> verification/testbench.sv
/*
 * self-checking bench for the scan-mode and power control block.
 * assumes asp_cfg.svh on the include path and the host model beside it.
 */
`include "asp_cfg.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [15:0] word;
      logic [3:0]  scan;
      logic [3:0]  sel;
   } asp_row_type;

   logic       clk_in = 1'b0;
   logic       srst_in = 1'b1;
   logic       cs_n, sclk, sdi, start_n;
   logic       conv_done_in = 1'b0, avg_req_in = 1'b0, seq_wr_in = 1'b0;
   logic [7:0] seq_wr_addr_in = 8'h00, seq_last_in = 8'h00;
   logic [3:0] seq_wr_chan_in = 4'h0;
   logic [3:0] scan_mode_out, channel_selector_out, active_channel_out;
   logic [1:0] auto_power_mode_out, static_power_field_out;
   logic       ext_clock_mode_out, avg_en_out, core_power_out, bias_power_out;
   logic       convert_req_out, result_valid_out;
   int         bad_count = 0, n_checks = 0, cyc = 0, valid_cnt = 0, req_cnt = 0, v0;
   asp_row_type rows [23];
   logic [3:0] exp_seq [3] = '{4'h9, 4'h9, 4'h3};

   always #2 clk_in = ~clk_in;

   asp_host_model u_host (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk),
      .sdi_out(sdi), .start_n_out(start_n));

   asp_scan_power u_dut (.clk_in(clk_in), .srst_in(srst_in), .cs_n_pin_in(cs_n),
      .sclk_pin_in(sclk), .sdi_pin_in(sdi), .convert_start_pin_n_in(start_n),
      .conv_done_in(conv_done_in), .avg_req_in(avg_req_in), .seq_wr_in(seq_wr_in),
      .seq_wr_addr_in(seq_wr_addr_in), .seq_wr_chan_in(seq_wr_chan_in),
      .seq_last_in(seq_last_in), .scan_mode_out(scan_mode_out),
      .channel_selector_out(channel_selector_out),
      .active_channel_out(active_channel_out),
      .auto_power_mode_out(auto_power_mode_out),
      .static_power_field_out(static_power_field_out),
      .ext_clock_mode_out(ext_clock_mode_out), .avg_en_out(avg_en_out),
      .core_power_out(core_power_out), .bias_power_out(bias_power_out),
      .convert_req_out(convert_req_out), .result_valid_out(result_valid_out));

   always @(posedge clk_in) begin
      if (result_valid_out === 1'b1) valid_cnt++;
      if (convert_req_out === 1'b1) req_cnt++;
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         $display("unexpected at %0t: run too long", $time);
         wrap_up();
      end
   end

   function automatic logic [15:0] mk(input logic [3:0] sc, input logic [3:0] sel,
                                      input logic [1:0] pm, input logic sw);
      mk = {1'b0, sc, sel, 1'b0, pm, 2'h0, sw, 1'b0};
   endfunction

   function automatic logic [15:0] cfg(input logic [1:0] static_power_field);
      cfg = {12'h800, static_power_field, 2'h0};
   endfunction

   task automatic chk4(input logic [3:0] got, input logic [3:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      chk4({3'h0, got}, {3'h0, exp}, what);
   endtask

   task automatic power(input logic core, input logic bias);
      chk1(core_power_out, core, "core power");
      chk1(bias_power_out, bias, "bias power");
   endtask

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, bad_count);
   endtask

   task automatic done_pulse();
      @(negedge clk_in) conv_done_in = 1'b1;
      @(negedge clk_in) conv_done_in = 1'b0;
      repeat (4) @(negedge clk_in);
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (6) @(negedge clk_in);
      srst_in = 1'b0;
      @(negedge clk_in);
      chk4(scan_mode_out, `ASP_SCAN_RESET, "reset scan");
      chk4(channel_selector_out, 4'h0, "reset selector");
      chk4({auto_power_mode_out, static_power_field_out}, 4'h0, "reset fields");
      chk1(ext_clock_mode_out, 1'b1, "reset clock mode");
      chk1(avg_en_out, 1'b0, "reset averaging");
      power(1'b1, 1'b1);
      end_test("reset");
      for (int i = 0; i < 16; i++) rows[i] = '{mk(4'h4, 4'(i), 2'h0, 1'b0), 4'h4, 4'(i)};
      rows[16] = '{mk(4'h6, 4'h7, 2'h0, 1'b0), 4'h6, 4'h7};
      for (int i = 0; i < 6; i++)
         rows[17 + i] = '{mk(`ASP_SCAN_RSV_MIN + 4'(i), 4'h1, 2'h1, 1'b1), 4'h6, 4'h7};
      foreach (rows[i]) begin
         u_host.send_word(rows[i].word);
         chk4(scan_mode_out, rows[i].scan, "scan mode");
         chk4(channel_selector_out, rows[i].sel, "selector");
         chk4(active_channel_out, rows[i].sel, "active channel");
         chk4({2'h0, auto_power_mode_out}, 4'h0, "auto field");
         power(1'b1, 1'b1);
      end
      end_test("rows");
      u_host.send_word(mk(4'h4, 4'h2, `ASP_PM_FULL_OFF, 1'b0));
      power(1'b1, 1'b1);
      u_host.send_word(mk(4'hc, 4'h5, 2'h0, 1'b0));
      power(1'b0, 1'b0);
      chk4(channel_selector_out, 4'h2, "selector kept");
      chk4({2'h0, auto_power_mode_out}, 4'h1, "field kept");
      fork
         u_host.send_word(mk(4'h4, 4'h2, `ASP_PM_NORMAL, 1'b0));
         begin
            repeat (60) @(negedge clk_in);
            power(1'b1, 1'b1);
         end
      join
      power(1'b1, 1'b1);
      for (int i = 0; i < 3; i++) begin
         v0 = valid_cnt;
         u_host.send_word(mk(4'h4, 4'h2, `ASP_PM_NORMAL, 1'b0));
         chk4(4'(valid_cnt - v0), (i == 2) ? 4'h1 : 4'h0, "valid results");
      end
      end_test("auto off");
      u_host.send_word(mk(4'h4, 4'h2, `ASP_PM_BIAS_KEEP, 1'b0));
      u_host.send_word(mk(4'h4, 4'h2, `ASP_PM_BIAS_KEEP, 1'b0));
      power(1'b0, 1'b1);
      u_host.send_word(mk(4'h4, 4'h2, `ASP_PM_NORMAL, 1'b0));
      u_host.send_word(mk(4'h4, 4'h2, `ASP_PM_NORMAL, 1'b0));
      power(1'b1, 1'b1);
      end_test("standby");
      for (int i = 1; i < 4; i++) begin
         u_host.send_word(cfg(2'(i % 3)));
         chk4({2'h0, static_power_field_out}, 4'(i % 3), "static field");
         power(i == 3, i != 1);
      end
      end_test("static");
      avg_req_in = 1'b1;
      u_host.send_word(mk(`ASP_SCAN_STD_INT, 4'h2, `ASP_PM_FULL_OFF, 1'b0));
      chk1(ext_clock_mode_out, 1'b0, "internal clock");
      chk1(avg_en_out, 1'b1, "averaging internal");
      done_pulse();
      power(1'b0, 1'b0);
      v0 = req_cnt;
      u_host.pulse_start();
      repeat (10) @(negedge clk_in);
      power(1'b1, 1'b1);
      chk4(4'(req_cnt - v0), 4'h1, "start requests");
      done_pulse();
      power(1'b0, 1'b0);
      u_host.send_word(mk(`ASP_SCAN_STD_INT, 4'h2, `ASP_PM_FULL_OFF, 1'b1));
      power(1'b1, 1'b1);
      for (int i = 0; i < 2; i++) begin
         u_host.send_word(mk(i ? `ASP_SCAN_CUS_INT : `ASP_SCAN_UPR_INT, 4'h2,
                             `ASP_PM_NORMAL, 1'b0));
         chk1(ext_clock_mode_out, 1'b0, "other internal codes");
         power(1'b1, 1'b1);
      end
      end_test("internal");
      for (int i = 0; i < 3; i++) begin
         @(negedge clk_in);
         seq_wr_in = 1'b1;
         seq_wr_addr_in = 8'(i);
         seq_wr_chan_in = exp_seq[i];
      end
      @(negedge clk_in) seq_wr_in = 1'b0;
      seq_last_in = 8'h02;
      u_host.send_word(mk(`ASP_SCAN_SEQ, 4'h0, `ASP_PM_NORMAL, 1'b0));
      chk1(ext_clock_mode_out, 1'b1, "sequence clock");
      chk1(avg_en_out, 1'b0, "sequence averaging");
      for (int i = 0; i < 3 && active_channel_out !== 4'h3; i++)
         u_host.send_word(mk(4'hf, 4'h0, 2'h0, 1'b0));
      chk4(active_channel_out, 4'h3, "sequence last");
      foreach (exp_seq[i]) begin
         u_host.send_word(mk(4'hf, 4'h0, 2'h0, 1'b0));
         chk4(active_channel_out, exp_seq[i], "sequence entry");
      end
      end_test("sequence");
      @(negedge clk_in) srst_in = 1'b1;
      repeat (6) @(negedge clk_in);
      srst_in = 1'b0;
      @(negedge clk_in);
      chk4(scan_mode_out, `ASP_SCAN_RESET, "mid-run reset scan");
      chk4(active_channel_out, 4'h0, "mid-run reset channel");
      power(1'b1, 1'b1);
      end_test("mid-run reset");
      wrap_up();
   end
endmodule
